// ---- logic/opaddr_pkg.sv ----
// package: constants for operand addressing and space selection
`default_nettype none
package opaddr_pkg;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned ADDR_W = 16;
   localparam logic [7:0] SPECIAL_BASE = 8'h80;
   localparam logic [7:0] BANK_TOP = 8'h1F;
   localparam logic [7:0] BIT_RAM_BASE = 8'h20;
   localparam logic [6:0] BIT_RAM_MASK = 7'h0F;
   localparam logic [15:0] ONCHIP_PROG_TOP = 16'h0FFF;
   localparam int unsigned CLK_HZ = 40000000;
   localparam int unsigned OSC_HZ = 12000000;
   localparam int unsigned OSC_PER_CYCLE = 12;
   // machine cycle of the core = 12 oscillator periods (1 us at 12 MHz)
   localparam int unsigned MC_TICKS = (CLK_HZ / OSC_HZ) * OSC_PER_CYCLE
      + ((CLK_HZ % OSC_HZ) * OSC_PER_CYCLE) / OSC_HZ;
   localparam int unsigned MULDIV_CYCLES = 4;
   localparam int unsigned LONG_CYCLES = 2;
   localparam int unsigned SHORT_CYCLES = 1;

   typedef enum logic [2:0] {
      AM_REGISTER, AM_DIRECT, AM_INDIRECT, AM_IMMEDIATE, AM_BASE_INDEX
   } addr_mode_e;

   typedef enum logic [2:0] {
      SP_NONE, SP_IRAM, SP_SPECIAL, SP_XDATA, SP_CODE, SP_IMM
   } space_e;

   typedef enum logic [1:0] {
      KIND_DATA, KIND_BIT, KIND_BRANCH
   } op_kind_e;

   typedef enum logic [1:0] {
      TGT_REL, TGT_BASE_INDEX, TGT_ABS16, TGT_NONE
   } target_e;

   typedef enum logic [1:0] {
      DUR_SHORT, DUR_LONG, DUR_MULDIV
   } dur_e;
endpackage
`default_nettype wire

// ---- logic/opaddr_if.sv ----
// interface: start, duration, busy and done handshake between core and cycle timer
`default_nettype none
interface opaddr_if;
   logic start;
   opaddr_pkg::dur_e dur;
   logic busy;
   logic done;
   modport core (output start, output dur, input busy, input done);
   modport timer (input start, input dur, output busy, output done);
endinterface
`default_nettype wire

// ---- logic/cycle_timer.sv ----
// module: instruction duration timer in machine cycles
`default_nettype none
module cycle_timer (
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // timing link
   opaddr_if.timer tl
);
   logic [7:0] tick;
   logic [2:0] cycles;

   // one-cycle machine-cycle enable from the system clock
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         tick <= 8'h00;
      // a refused start while busy must not shift the machine-cycle phase
      end else if (tick == 8'(opaddr_pkg::MC_TICKS - 1) ||
                   (tl.start && !tl.busy)) begin
         tick <= 8'h00;
      end else begin
         tick <= tick + 8'h01;
      end
   end

   // muldiv takes four machine cycles, twice the longest other
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         cycles <= 3'h0;
         tl.busy <= 1'b0;
         tl.done <= 1'b0;
      end else begin
         tl.done <= 1'b0;
         if (tl.start && !tl.busy) begin
            tl.busy <= 1'b1;
            case (tl.dur)
               opaddr_pkg::DUR_MULDIV:
                  cycles <= 3'(opaddr_pkg::MULDIV_CYCLES);
               opaddr_pkg::DUR_LONG:
                  cycles <= 3'(opaddr_pkg::LONG_CYCLES);
               default: cycles <= 3'(opaddr_pkg::SHORT_CYCLES);
            endcase
         end else if (tl.busy &&
                      tick == 8'(opaddr_pkg::MC_TICKS - 1)) begin
            if (cycles == 3'h1) begin
               tl.busy <= 1'b0;
               tl.done <= 1'b1;
            end
            cycles <= cycles - 3'h1;
         end
      end
   end
endmodule // cycle_timer
`default_nettype wire

// ---- logic/operand_address_space_decode.sv ----
// module: operand addressing, memory-space selection and branch targets
//
// How it works
// - internal data space: 256-byte RAM plus separate 128-byte register space
// - four banks of eight working registers live in internal RAM
// - stack sits in internal RAM at the 8-bit stack pointer
// - 128 bit locations are addressable inside internal RAM
// - 128 bit locations in register space are addressable as bits
// - conditional branch target is program counter plus signed offset
// - indirect jump target is 16-bit base plus 8-bit index
// - full 16-bit jump and call targets reach all 64K without paging
// - sources take five addressing modes, destinations only first three
// - non-move operations also read the destination operand
// - bank registers reachable by register, direct or indirect modes
// - internal RAM reachable by direct or indirect modes
// - register space reachable only by direct addressing
// - external data memory reached only by register-indirect mode
// - program-memory tables read by base plus index indirect mode
// - datapath is 8 bits; bit, nibble, byte, double-byte operands
// - boolean moves, logic and branches act on single bits
// - 64K program and 64K external data spaces, 16-bit counter
// - lowest 4K program from on-chip store when fitted, else external
// - most instructions take 1 or 2 us, muldiv 4 us at 12 MHz
`default_nettype none
module operand_address_space_decode #(
   parameter bit HAS_ONCHIP_PROG = 1'b1
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // decoded instruction fields from the core
   input wire logic dec_valid,
   input wire opaddr_pkg::op_kind_e dec_kind,
   input wire opaddr_pkg::addr_mode_e src_mode,
   input wire opaddr_pkg::addr_mode_e dst_mode,
   input wire logic dst_used,
   input wire logic is_move,
   input wire logic dst_external,
   input wire opaddr_pkg::target_e tgt_sel,
   input wire opaddr_pkg::dur_e dur,
   input wire logic [2:0] src_reg,
   input wire logic [2:0] dst_reg,
   input wire logic [7:0] src_operand,
   input wire logic [7:0] dst_operand,
   input wire logic [15:0] abs_target,
   // core state
   input wire logic [1:0] bank_sel,
   input wire logic [7:0] stack_ptr,
   input wire logic [7:0] ptr_lo,
   input wire logic [15:0] ptr_16,
   input wire logic [7:0] index_reg,
   input wire logic [15:0] prog_ctr,
   input wire logic stack_push,
   // decoded results
   output logic out_valid,
   output logic illegal,
   output opaddr_pkg::space_e src_space,
   output logic [15:0] src_addr,
   output opaddr_pkg::space_e dst_space,
   output logic [15:0] dst_addr,
   output logic dst_read,
   output logic bit_op,
   output logic [7:0] bit_byte,
   output logic [2:0] bit_pos,
   output logic [15:0] next_target,
   output logic target_valid,
   output logic [7:0] stack_addr,
   output logic code_onchip,
   output logic busy,
   output logic done
);
   // ************************************************************
   // decode helpers
   // ************************************************************

   // direct address: top bit set selects register space
   function automatic opaddr_pkg::space_e direct_space(
      input logic [7:0] a);
      direct_space = (a >= opaddr_pkg::SPECIAL_BASE) ?
         opaddr_pkg::SP_SPECIAL : opaddr_pkg::SP_IRAM;
   endfunction

   // working registers sit in the low 32 bytes of internal RAM
   function automatic logic [7:0] bank_addr(
      input logic [1:0] b,
      input logic [2:0] r);
      bank_addr = {3'h0, b, r};
   endfunction

   // bit address to byte and bit position
   function automatic logic [7:0] bit_to_byte(input logic [7:0] a);
      if (a[7]) begin
         bit_to_byte = {a[7:3], 3'h0};
      end else begin
         bit_to_byte = opaddr_pkg::BIT_RAM_BASE
            + {4'h0, a[6:3]};
      end
   endfunction

   function automatic logic code_local(input logic [15:0] a);
      code_local = HAS_ONCHIP_PROG &&
         (a <= opaddr_pkg::ONCHIP_PROG_TOP);
   endfunction

   // ************************************************************
   // combinational operand routing
   // ************************************************************
   opaddr_pkg::space_e next_src_space;
   opaddr_pkg::space_e next_dst_space;
   logic [15:0] next_src_addr;
   logic [15:0] next_dst_addr;
   logic next_illegal;
   logic [15:0] base_index;

   // table reads and indirect jumps share one 16-bit adder
   assign base_index = ptr_16 + {8'h00, index_reg};

   always_comb begin
      next_src_space = opaddr_pkg::SP_NONE;
      next_src_addr = 16'h0000;
      next_illegal = 1'b0;
      case (src_mode)
         opaddr_pkg::AM_REGISTER: begin
            next_src_space = opaddr_pkg::SP_IRAM;
            next_src_addr = {8'h00, bank_addr(bank_sel, src_reg)};
         end
         opaddr_pkg::AM_DIRECT: begin
            next_src_space = direct_space(src_operand);
            next_src_addr = {8'h00, src_operand};
         end
         opaddr_pkg::AM_INDIRECT: begin
            // indirect never reaches register space: top half is RAM
            if (dst_external) begin
               next_src_space = opaddr_pkg::SP_XDATA;
               next_src_addr = ptr_16;
            end else begin
               next_src_space = opaddr_pkg::SP_IRAM;
               next_src_addr = {8'h00, ptr_lo};
            end
         end
         opaddr_pkg::AM_IMMEDIATE: begin
            next_src_space = opaddr_pkg::SP_IMM;
            next_src_addr = {8'h00, src_operand};
         end
         opaddr_pkg::AM_BASE_INDEX: begin
            next_src_space = opaddr_pkg::SP_CODE;
            next_src_addr = base_index;
         end
         default: next_illegal = 1'b1;
      endcase

      next_dst_space = opaddr_pkg::SP_NONE;
      next_dst_addr = 16'h0000;
      if (dst_used) begin
         case (dst_mode)
            opaddr_pkg::AM_REGISTER: begin
               next_dst_space = opaddr_pkg::SP_IRAM;
               next_dst_addr = {8'h00, bank_addr(bank_sel, dst_reg)};
            end
            opaddr_pkg::AM_DIRECT: begin
               next_dst_space = direct_space(dst_operand);
               next_dst_addr = {8'h00, dst_operand};
            end
            opaddr_pkg::AM_INDIRECT: begin
               if (dst_external) begin
                  next_dst_space = opaddr_pkg::SP_XDATA;
                  next_dst_addr = ptr_16;
               end else begin
                  next_dst_space = opaddr_pkg::SP_IRAM;
                  next_dst_addr = {8'h00, ptr_lo};
               end
            end
            default: next_illegal = 1'b1;
         endcase
      end
   end

   // ************************************************************
   // registered decode results
   // ************************************************************
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         out_valid <= 1'b0;
         illegal <= 1'b0;
         src_space <= opaddr_pkg::SP_NONE;
         src_addr <= 16'h0000;
         dst_space <= opaddr_pkg::SP_NONE;
         dst_addr <= 16'h0000;
         dst_read <= 1'b0;
      end else begin
         out_valid <= dec_valid && dec_kind == opaddr_pkg::KIND_DATA;
         if (dec_valid && dec_kind == opaddr_pkg::KIND_DATA) begin
            illegal <= next_illegal;
            src_space <= next_src_space;
            src_addr <= next_src_addr;
            dst_space <= next_dst_space;
            dst_addr <= next_dst_addr;
            dst_read <= dst_used && !is_move;
         end
      end
   end

   // ************************************************************
   // boolean operand decode
   // ************************************************************
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         bit_op <= 1'b0;
         bit_byte <= 8'h00;
         bit_pos <= 3'h0;
      end else begin
         bit_op <= dec_valid && dec_kind == opaddr_pkg::KIND_BIT;
         if (dec_valid && dec_kind == opaddr_pkg::KIND_BIT) begin
            bit_byte <= bit_to_byte(src_operand);
            bit_pos <= src_operand[2:0];
         end
      end
   end

   // ************************************************************
   // branch and jump targets
   // ************************************************************
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         next_target <= 16'h0000;
         target_valid <= 1'b0;
         code_onchip <= 1'b0;
      end else begin
         target_valid <= 1'b0;
         if (dec_valid && dec_kind == opaddr_pkg::KIND_BRANCH) begin
            target_valid <= tgt_sel != opaddr_pkg::TGT_NONE;
            case (tgt_sel)
               opaddr_pkg::TGT_REL: begin
                  next_target <= prog_ctr
                     + {{8{src_operand[7]}}, src_operand};
                  code_onchip <= code_local(prog_ctr
                     + {{8{src_operand[7]}}, src_operand});
               end
               opaddr_pkg::TGT_BASE_INDEX: begin
                  next_target <= base_index;
                  code_onchip <= code_local(base_index);
               end
               opaddr_pkg::TGT_ABS16: begin
                  next_target <= abs_target;
                  code_onchip <= code_local(abs_target);
               end
               default: next_target <= next_target;
            endcase
         end
      end
   end

   // ************************************************************
   // stack pointer address
   // ************************************************************
   // pre-increment on push; depth limited only by RAM size
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         stack_addr <= 8'h00;
      end else begin
         stack_addr <= stack_push ? stack_ptr + 8'h01 : stack_ptr;
      end
   end

   // ************************************************************
   // instruction duration
   // ************************************************************
   opaddr_if tl ();
   assign tl.start = dec_valid;
   assign tl.dur = dur;

   cycle_timer u_timer (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .tl(tl)
   );

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         busy <= 1'b0;
         done <= 1'b0;
      end else begin
         busy <= tl.busy;
         done <= tl.done;
      end
   end

   // ************************************************************
   // checks
   // ************************************************************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);

   direct_high_space_a: assert property (
      dec_valid && dec_kind == opaddr_pkg::KIND_DATA &&
      src_mode == opaddr_pkg::AM_DIRECT && src_operand[7]
      |=> src_space == opaddr_pkg::SP_SPECIAL)
      else $error("direct high address not in register space");
   indirect_no_special_a: assert property (
      out_valid && src_space == opaddr_pkg::SP_SPECIAL
      |-> $past(src_mode) == opaddr_pkg::AM_DIRECT)
      else $error("register space reached without direct mode");
   dest_mode_limit_a: assert property (
      dec_valid && dec_kind == opaddr_pkg::KIND_DATA && dst_used &&
      dst_mode == opaddr_pkg::AM_IMMEDIATE |=> illegal)
      else $error("immediate destination accepted");
   dest_read_a: assert property (
      dec_valid && dec_kind == opaddr_pkg::KIND_DATA && dst_used &&
      !is_move |=> dst_read)
      else $error("destination not read for non-move");
   rel_branch_a: assert property (
      dec_valid && dec_kind == opaddr_pkg::KIND_BRANCH &&
      tgt_sel == opaddr_pkg::TGT_REL |=> target_valid &&
      next_target == $past(prog_ctr) +
         {{8{$past(src_operand[7])}}, $past(src_operand)})
      else $error("relative target wrong");
   base_index_a: assert property (
      dec_valid && dec_kind == opaddr_pkg::KIND_BRANCH &&
      tgt_sel == opaddr_pkg::TGT_BASE_INDEX |=>
      next_target == $past(ptr_16) + {8'h00, $past(index_reg)})
      else $error("indexed jump target wrong");
   bank_reg_a: assert property (
      dec_valid && dec_kind == opaddr_pkg::KIND_DATA &&
      src_mode == opaddr_pkg::AM_REGISTER |=>
      src_addr[7:0] <= opaddr_pkg::BANK_TOP)
      else $error("bank register outside low RAM");
   bit_ram_a: assert property (
      bit_op && !bit_byte[7] |->
      bit_byte[7:4] == opaddr_pkg::BIT_RAM_BASE[7:4] ||
      bit_byte[7:4] == 4'h3) else $error("ram bit byte out of area");
   muldiv_len_a: assert property (
      dec_valid && !busy && !tl.busy && dur == opaddr_pkg::DUR_MULDIV
      |=> tl.busy [*8] ##152 tl.busy ##1 !tl.busy)
      else $error("muldiv length wrong");
   ext_indirect_a: assert property (
      out_valid && src_space == opaddr_pkg::SP_XDATA |->
      $past(src_mode) == opaddr_pkg::AM_INDIRECT)
      else $error("external data without indirect mode");

   cov_special_c: cover property (out_valid &&
      src_space == opaddr_pkg::SP_SPECIAL);
   cov_table_c: cover property (out_valid &&
      src_space == opaddr_pkg::SP_CODE);
   cov_bit_c: cover property (bit_op && bit_byte[7]);
   cov_done_c: cover property (done);
endmodule // operand_address_space_decode
`default_nettype wire

// ---- testbench/testbench.sv ----
// testbench: operand addressing and space decode, random plus corner cases
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;

   // ****************************************
   // stimulus and observed signals
   // ****************************************
   logic clk_sys = 1'b0;
   logic reset_n;
   logic dec_valid, dst_used, is_move, dst_external, stack_push;
   opaddr_pkg::op_kind_e dec_kind;
   opaddr_pkg::addr_mode_e src_mode, dst_mode;
   opaddr_pkg::target_e tgt_sel;
   opaddr_pkg::dur_e dur;
   logic [2:0] src_reg, dst_reg, bit_pos;
   logic [7:0] src_operand, dst_operand, stack_ptr, ptr_lo, index_reg;
   logic [15:0] abs_target, ptr_16, prog_ctr;
   logic [1:0] bank_sel;
   logic out_valid, illegal, dst_read, bit_op, target_valid, code_onchip;
   logic busy, done;
   opaddr_pkg::space_e src_space, dst_space;
   logic [15:0] src_addr, dst_addr, next_target;
   logic [7:0] bit_byte, stack_addr;
   logic [7:0] edge_v [4] = '{8'h00, 8'h7F, 8'h80, 8'hFF};
   logic [15:0] edge_pc [4] = '{16'h0000, 16'h0FFF, 16'h1000, 16'hFFFF};
   int err_total = 0;
   int checks = 0;
   int cycles = 0;

   operand_address_space_decode #(.HAS_ONCHIP_PROG(1'b1)) DUT (
      .clk_sys(clk_sys), .reset_n(reset_n), .dec_valid(dec_valid),
      .dec_kind(dec_kind), .src_mode(src_mode), .dst_mode(dst_mode),
      .dst_used(dst_used), .is_move(is_move), .dst_external(dst_external),
      .tgt_sel(tgt_sel), .dur(dur), .src_reg(src_reg), .dst_reg(dst_reg),
      .src_operand(src_operand), .dst_operand(dst_operand),
      .abs_target(abs_target), .bank_sel(bank_sel), .stack_ptr(stack_ptr),
      .ptr_lo(ptr_lo), .ptr_16(ptr_16), .index_reg(index_reg),
      .prog_ctr(prog_ctr), .stack_push(stack_push), .out_valid(out_valid),
      .illegal(illegal), .src_space(src_space), .src_addr(src_addr),
      .dst_space(dst_space), .dst_addr(dst_addr), .dst_read(dst_read),
      .bit_op(bit_op), .bit_byte(bit_byte), .bit_pos(bit_pos),
      .next_target(next_target), .target_valid(target_valid),
      .stack_addr(stack_addr), .code_onchip(code_onchip), .busy(busy),
      .done(done)
   );

   always #12.5 clk_sys = ~clk_sys;

   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         err_total++;
         test_done();
      end
   end

   // ****************************************
   // helpers
   // ****************************************
   task automatic test_done();
      if (err_total == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic rand_fields();
      dec_kind = opaddr_pkg::op_kind_e'($urandom_range(0, 2));
      src_mode = opaddr_pkg::addr_mode_e'($urandom_range(0, 4));
      dst_mode = opaddr_pkg::addr_mode_e'($urandom_range(0, 4));
      tgt_sel = opaddr_pkg::target_e'($urandom_range(0, 3));
      dur = opaddr_pkg::dur_e'($urandom_range(0, 2));
      {dst_used, is_move, stack_push, bank_sel, src_reg, dst_reg} =
         11'($urandom);
      // external select steers both indirect operands to external data
      dst_external = 1'($urandom);
      {src_operand, dst_operand, stack_ptr, ptr_lo} = $urandom;
      {abs_target, ptr_16} = $urandom;
      {index_reg, prog_ctr} = 24'($urandom);
   endtask

   task automatic exp_loc(input opaddr_pkg::addr_mode_e m,
      input logic [2:0] r, input logic [7:0] a, input logic ext,
      output opaddr_pkg::space_e s, output logic [15:0] ad);
      s = opaddr_pkg::SP_IRAM;
      ad = {8'h00, a};
      case (m)
         opaddr_pkg::AM_REGISTER: ad = {11'h000, bank_sel, r};
         opaddr_pkg::AM_DIRECT: if (a >= opaddr_pkg::SPECIAL_BASE)
            s = opaddr_pkg::SP_SPECIAL;
         opaddr_pkg::AM_INDIRECT: begin
            s = ext ? opaddr_pkg::SP_XDATA : opaddr_pkg::SP_IRAM;
            ad = ext ? ptr_16 : {8'h00, ptr_lo};
         end
         opaddr_pkg::AM_IMMEDIATE: s = opaddr_pkg::SP_IMM;
         default: begin
            s = opaddr_pkg::SP_CODE;
            ad = ptr_16 + {8'h00, index_reg};
         end
      endcase
   endtask

   task automatic check_all();
      opaddr_pkg::space_e s;
      logic [15:0] a;
      logic [7:0] b;
      logic bad;
      bad = dst_used && (dst_mode > opaddr_pkg::AM_INDIRECT);
      case (dec_kind)
         opaddr_pkg::KIND_DATA: begin
            chk(illegal, bad);
            if (!bad) begin
               chk(out_valid, 1'b1);
               exp_loc(src_mode, src_reg, src_operand, dst_external, s, a);
               chk({src_space, src_addr}, {s, a});
               if (dst_used) begin
                  exp_loc(dst_mode, dst_reg, dst_operand, dst_external, s, a);
                  chk({dst_space, dst_addr}, {s, a});
                  chk(dst_read, !is_move);
               end
               b = stack_push ? stack_ptr + 8'h01 : stack_ptr;
               chk(stack_addr, b);
            end
         end
         opaddr_pkg::KIND_BIT: begin
            b = src_operand[7] ? {src_operand[7:3], 3'h0}
               : opaddr_pkg::BIT_RAM_BASE + {4'h0, src_operand[6:3]};
            chk(bit_op, 1'b1);
            chk({bit_byte, bit_pos}, {b, src_operand[2:0]});
         end
         default: begin
            case (tgt_sel)
               opaddr_pkg::TGT_REL:
                  a = prog_ctr + {{8{src_operand[7]}}, src_operand};
               opaddr_pkg::TGT_BASE_INDEX: a = ptr_16 + {8'h00, index_reg};
               default: a = abs_target;
            endcase
            chk(target_valid, tgt_sel != opaddr_pkg::TGT_NONE);
            if (tgt_sel != opaddr_pkg::TGT_NONE) begin
               chk(next_target, a);
               chk(code_onchip, a <= opaddr_pkg::ONCHIP_PROG_TOP);
            end
         end
      endcase
   endtask

   task automatic go();
      dec_valid = 1'b1;
      @(negedge clk_sys);
   endtask

   task automatic idle();
      dec_valid = 1'b0;
      @(negedge clk_sys);
      chk({out_valid, bit_op, target_valid}, 3'h0);
   endtask

   task automatic do_reset();
      reset_n = 1'b0;
      repeat (5) @(negedge clk_sys);
      chk({out_valid, bit_op, target_valid, busy, done}, 5'h00);
      chk(src_space, opaddr_pkg::SP_NONE);
      reset_n = 1'b1;
      @(negedge clk_sys);
   endtask

   // poke retriggers mid-run; a busy timer must not restart
   task automatic time_one(input opaddr_pkg::dur_e d, input int n,
      input bit poke);
      int k;
      int lo;
      k = 0;
      while (busy !== 1'b0 && k < 400) begin
         @(negedge clk_sys);
         k++;
      end
      rand_fields();
      dec_kind = opaddr_pkg::KIND_DATA;
      dur = d;
      dec_valid = 1'b1;
      @(negedge clk_sys);
      dec_valid = 1'b0;
      // the registered busy output follows the timer one clock later
      @(negedge clk_sys);
      k = 2;
      chk(busy, 1'b1);
      while (done !== 1'b1 && k < 400) begin
         @(negedge clk_sys);
         k++;
         dec_valid = poke && (k == 10);
      end
      lo = n * opaddr_pkg::MC_TICKS;
      // a few clocks of slack for the timer's registered start and end
      chk(k >= lo && k <= lo + 4, 1'b1);
      @(negedge clk_sys);
      chk(busy, 1'b0);
   endtask

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      void'($urandom(32'h6b35));
      reset_n = 1'b0;
      dec_valid = 1'b0;
      rand_fields();
      do_reset();
      foreach (edge_v[i]) begin
         for (int k = 0; k < 4; k++) begin
            rand_fields();
            dec_kind = opaddr_pkg::op_kind_e'(k > 2 ? 2 : k);
            src_mode = opaddr_pkg::AM_DIRECT;
            src_operand = edge_v[i];
            prog_ctr = edge_pc[i];
            abs_target = edge_pc[i];
            tgt_sel = (k == 3) ? opaddr_pkg::TGT_ABS16 : opaddr_pkg::TGT_REL;
            go();
            check_all();
            idle();
         end
      end
      for (int i = 0; i < 150; i++) begin
         rand_fields();
         go();
         check_all();
         if ($urandom_range(0, 3) != 0)
            idle();
      end
      idle();
      dec_kind = opaddr_pkg::KIND_DATA;
      dur = opaddr_pkg::DUR_MULDIV;
      go();
      dec_valid = 1'b0;
      repeat (20) @(negedge clk_sys);
      do_reset();
      time_one(opaddr_pkg::DUR_SHORT, 1, 1'b0);
      time_one(opaddr_pkg::DUR_LONG, 2, 1'b1);
      time_one(opaddr_pkg::DUR_MULDIV, 4, 1'b0);
      test_done();
   end
endmodule // testbench
`default_nettype wire
